// file: core/rvc_pkg.sv
// Shared constants and types for the receive-port video config and status block
package rvc_pkg;

   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned MEAS_WINDOW_NS = 1000;
   localparam int unsigned MEAS_WINDOW_CYC = MEAS_WINDOW_NS / CLK_PERIOD_NS;
   localparam int unsigned STABLE_T0_NS   = 40000;
   localparam int unsigned STABLE_T1_NS   = 80000;
   localparam int unsigned STABLE_T2_NS   = 320000;
   localparam int unsigned STABLE_T3_NS   = 1280000;
   localparam int unsigned STABLE_W       = 11;
   localparam logic [STABLE_W-1:0] STABLE_T0_WIN = STABLE_W'(STABLE_T0_NS / MEAS_WINDOW_NS);
   localparam logic [STABLE_W-1:0] STABLE_T1_WIN = STABLE_W'(STABLE_T1_NS / MEAS_WINDOW_NS);
   localparam logic [STABLE_W-1:0] STABLE_T2_WIN = STABLE_W'(STABLE_T2_NS / MEAS_WINDOW_NS);
   localparam logic [STABLE_W-1:0] STABLE_T3_WIN = STABLE_W'(STABLE_T3_NS / MEAS_WINDOW_NS);

   // Bus geometry
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned IDX_W  = 8;
   localparam logic [1:0]  WORD_OFS = 2'h0;

   // Register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_PORT_CONFIG = 8'h6D;
   localparam logic [IDX_W-1:0] IDX_BC_SEL_LO   = 8'h6E;
   localparam logic [IDX_W-1:0] IDX_BC_SEL_HI   = 8'h6F;
   localparam logic [IDX_W-1:0] IDX_RAW_TEN_BIT_STREAM_ID    = 8'h70;
   localparam logic [IDX_W-1:0] IDX_RAW_TWELVE_BIT_STREAM_ID    = 8'h71;
   localparam logic [IDX_W-1:0] IDX_RESERVED    = 8'h72;
   localparam logic [IDX_W-1:0] IDX_LINES_HI    = 8'h73;
   localparam logic [IDX_W-1:0] IDX_LINES_LO    = 8'h74;
   localparam logic [IDX_W-1:0] IDX_LEN_HI      = 8'h75;
   localparam logic [IDX_W-1:0] IDX_LEN_LO      = 8'h76;
   localparam logic [IDX_W-1:0] IDX_FREQ_CTL    = 8'h77;
   localparam logic [IDX_W-1:0] IDX_CLK_STATUS  = 8'h80;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 8'h81;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 8'h82;

   // Reset values and selector codes
   localparam logic [3:0] BC_SEL_RST     = 4'h8;
   localparam logic [3:0] BC_CONST0      = 4'h8;
   localparam logic [3:0] BC_CONST1      = 4'h9;
   localparam logic [3:0] BC_SYNC        = 4'hA;
   localparam logic [5:0] DT_RAW10_RST   = 6'h2B;
   localparam logic [5:0] DT_RAW12_RST   = 6'h2C;
   localparam logic [1:0] HYST_RST       = 2'h3;
   localparam logic [1:0] STABLE_SEL_RST = 2'h0;
   localparam logic [3:0] LOW_THR_RST    = 4'h5;

   // Interrupt bit positions
   localparam int unsigned IRQ_W      = 4;
   localparam int unsigned IRQ_LINES  = 0;
   localparam int unsigned IRQ_LEN    = 1;
   localparam int unsigned IRQ_STABLE = 2;
   localparam int unsigned IRQ_SLOW   = 3;

   typedef enum logic [1:0] {
      FMT_RESERVED = 2'b00,
      FMT_RAW12_LF = 2'b01,
      FMT_RAW12_HF = 2'b10,
      FMT_RAW10    = 2'b11
   } rvc_fmt_e;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } rvc_bus_e;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic              read;
      logic              write;
      logic [DATA_W-1:0] writedata;
      logic [3:0]        byteenable;
   } rvc_avs_req_s;

   typedef struct packed {
      logic [DATA_W-1:0] readdata;
      logic              waitrequest;
   } rvc_avs_rsp_s;

   typedef struct packed {
      logic frame_valid;
      logic line_valid;
      logic pixel_valid;
   } rvc_video_s;

   typedef struct packed {
      logic [1:0] ten_bit_virtual_channel;
      logic [5:0] ten_bit_data_type;
      logic [1:0] twelve_bit_virtual_channel;
      logic [5:0] twelve_bit_data_type;
   } rvc_stream_ids_s;

   typedef struct packed {
      logic [1:0] clock_measure_hysteresis;
      logic [1:0] clock_stable_time_select;
      logic [3:0] clock_too_slow_threshold;
   } rvc_freq_cfg_s;

endpackage

// file: core/rvc_freq_det.sv
// Link clock frequency detector with hysteresis and stability timer
`timescale 1ns/1ns
module rvc_freq_det
   import rvc_pkg::*;
(
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          sys_rst,
   // One pulse per link clock cycle, synchronous
   input  wire logic          clk_tick,
   input  wire rvc_freq_cfg_s cfg,
   // Measurement results
   output logic [7:0]         measured_mhz,
   output logic               clock_stable,
   output logic               clock_too_slow
);

   typedef struct packed {
      logic [6:0]          win_cnt;
      logic [7:0]          tick_cnt;
      logic [7:0]          cur;
      logic [STABLE_W-1:0] stable_cnt;
      logic                stable;
      logic                slow;
   } rvc_fd_s;

   rvc_fd_s state_ff;
   rvc_fd_s nxt_state;
   logic [7:0]          diff;
   logic [STABLE_W-1:0] target;

   // Window of one microsecond, so the tick count reads directly in MHz
   always_comb begin
      nxt_state = state_ff;
      target    = STABLE_T0_WIN;
      unique case (cfg.clock_stable_time_select)
         2'b00: target = STABLE_T0_WIN; // R17
         2'b01: target = STABLE_T1_WIN; // R17
         2'b10: target = STABLE_T2_WIN; // R17
         2'b11: target = STABLE_T3_WIN; // R17
      endcase
      diff = (state_ff.tick_cnt > state_ff.cur) ? state_ff.tick_cnt - state_ff.cur
                                                : state_ff.cur - state_ff.tick_cnt;
      nxt_state.tick_cnt = state_ff.tick_cnt + 8'(clk_tick);
      nxt_state.win_cnt  = state_ff.win_cnt + 7'h01;
      if (state_ff.win_cnt == 7'(MEAS_WINDOW_CYC - 1)) begin
         nxt_state.win_cnt  = 7'h00;
         nxt_state.tick_cnt = 8'(clk_tick);
         if (diff > 8'(cfg.clock_measure_hysteresis)) begin
            // Jump beyond hysteresis restarts the stability timer
            nxt_state.cur        = state_ff.tick_cnt; // R16
            nxt_state.stable_cnt = '0;
            nxt_state.stable     = 1'b0;
         end else if (state_ff.stable_cnt < target) begin
            nxt_state.stable_cnt = state_ff.stable_cnt + STABLE_W'(1);
         end
         nxt_state.stable = (diff <= 8'(cfg.clock_measure_hysteresis))
                            && (state_ff.stable_cnt + STABLE_W'(1) >= target); // R17
      end
      // Compares the held measurement, not the running count
      nxt_state.slow = (nxt_state.cur < 8'(cfg.clock_too_slow_threshold)); // R18
   end

   // State register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign measured_mhz   = state_ff.cur;
   assign clock_stable   = state_ff.stable;
   assign clock_too_slow = state_ff.slow;

endmodule

// file: core/rvc_port_regs.sv
// Receive-port video configuration and status registers with Avalon-MM slave
//
// Contract
// R1: Two-bit field selects link receive format
// R2: Selector code 0xxx forwards local pin
// R3: Codes 1000/1001 send constant zero/one
// R4: Code 1010 sends camera sync; others reserved
// R5: All selectors reset to 0x8
// R6: Ten-bit virtual channel resets to port number
// R7: Ten-bit data type resets to 0x2B
// R8: Twelve-bit virtual channel resets to port number
// R9: Twelve-bit data type resets to 0x2C
// R10: Frame line count in two bytes
// R11: Line count frozen until read when enabled
// R12: High byte read latches low byte
// R13: Report last line length of frame
// R14: Line length frozen until read when enabled
// R15: Length high byte read latches low byte
// R16: New measurement only beyond hysteresis, reset 3
// R17: Stability time 40us/80us/320us/1.28ms
// R18: Too-slow threshold low nibble, reset 5
// R19: Status updates once at frame end
`timescale 1ns/1ns
module rvc_port_regs
   import rvc_pkg::*;
#(
   parameter logic [1:0] PORT_NUM = 2'h0
)(
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            sys_rst,
   // Avalon-MM slave
   input  wire rvc_avs_req_s    avs_req,
   output rvc_avs_rsp_s         avs_rsp,
   // Video timing from the receiver
   input  wire rvc_video_s      video,
   input  wire logic            link_clk_tick,
   input  wire logic [1:0]      strap_link_format,
   // Back-channel sources
   input  wire logic [7:0]      local_pins,
   input  wire logic            camera_sync_pulse,
   // Outputs to the port datapath
   output logic [3:0]           backchannel_bits,
   output rvc_fmt_e             link_input_format,
   output rvc_stream_ids_s      stream_ids,
   output logic                 clock_stable,
   output logic                 clock_too_slow,
   output logic                 irq
);

   typedef struct packed {
      rvc_bus_e          bus;
      logic [DATA_W-1:0] rdata;
      logic              strap_pend;
      rvc_fmt_e          fmt;
      logic [15:0]       bc_sel;
      rvc_stream_ids_s   ids;
      logic [7:0]        rsvd;
      rvc_freq_cfg_s     fcfg;
      logic [IRQ_W-1:0]  irq_status;
      logic [IRQ_W-1:0]  irq_mask;
      logic              irq;
      logic              fv_d;
      logic              lv_d;
      logic [15:0]       lines_run;
      logic [15:0]       len_run;
      logic [15:0]       len_last;
      logic [15:0]       lines_rep;
      logic [15:0]       len_rep;
      logic              lines_frz;
      logic              len_frz;
      logic [7:0]        lines_lo_hold;
      logic [7:0]        len_lo_hold;
      logic              stable_d;
      logic              slow_d;
      logic [3:0]        bc_out;
   } rvc_regs_s;

   localparam rvc_regs_s RST_STATE = '{
      bus:           BUS_IDLE,
      rdata:         '0,
      strap_pend:    1'b1,
      fmt:           FMT_RESERVED,
      bc_sel:        {4{BC_SEL_RST}},
      ids:           '{ten_bit_virtual_channel:    PORT_NUM,
                       ten_bit_data_type:          DT_RAW10_RST,
                       twelve_bit_virtual_channel: PORT_NUM,
                       twelve_bit_data_type:       DT_RAW12_RST},
      rsvd:          '0,
      fcfg:          '{clock_measure_hysteresis: HYST_RST,
                       clock_stable_time_select: STABLE_SEL_RST,
                       clock_too_slow_threshold: LOW_THR_RST},
      irq_status:    '0,
      irq_mask:      '0,
      irq:           1'b0,
      fv_d:          1'b0,
      lv_d:          1'b0,
      lines_run:     '0,
      len_run:       '0,
      len_last:      '0,
      lines_rep:     '0,
      len_rep:       '0,
      lines_frz:     1'b0,
      len_frz:       1'b0,
      lines_lo_hold: '0,
      len_lo_hold:   '0,
      stable_d:      1'b0,
      slow_d:        1'b0,
      bc_out:        '0
   };

   rvc_regs_s         state_ff;
   rvc_regs_s         nxt_state;
   logic [3:0]        bc_bit;
   logic [7:0]        meas_mhz;
   logic              fd_stable;
   logic              fd_slow;
   logic [IDX_W-1:0]  idx;
   logic              aligned;
   logic              accept;
   logic              wr_ack;
   logic [7:0]        wbyte;
   logic [7:0]        rbyte;
   logic [IRQ_W-1:0]  evt;
   logic              frame_end;
   logic              line_end;
   logic [15:0]       len_final;

   // Frequency detector sees the live config fields
   rvc_freq_det u_freq_det (
      .clock          (clock),
      .sys_rst        (sys_rst),
      .clk_tick       (link_clk_tick),
      .cfg            (state_ff.fcfg),
      .measured_mhz   (meas_mhz),
      .clock_stable   (fd_stable),
      .clock_too_slow (fd_slow)
   );

   // Per-bit back-channel source mux
   for (genvar g = 0; g < 4; g++) begin : g_bc
      logic [3:0] sel;
      assign sel = state_ff.bc_sel[g*4 +: 4];
      always_comb begin
         if (!sel[3]) begin
            bc_bit[g] = local_pins[sel[2:0]]; // R2
         end else if (sel == BC_CONST1) begin
            bc_bit[g] = 1'b1; // R3
         end else if (sel == BC_SYNC) begin
            bc_bit[g] = camera_sync_pulse; // R4
         end else begin
            // Constant zero code, reserved codes also send zero
            bc_bit[g] = 1'b0; // R3
         end
      end
   end

   // Bus decode; unaligned byte addresses fall into the unmapped space
   assign idx     = avs_req.address[ADDR_W-1:2];
   assign aligned = (avs_req.address[1:0] == WORD_OFS);
   assign accept  = (avs_req.read || avs_req.write) && (state_ff.bus == BUS_IDLE);
   assign wr_ack  = avs_req.write && (state_ff.bus == BUS_ACK) && avs_req.byteenable[0]
                    && aligned;
   assign wbyte   = avs_req.writedata[7:0];

   // Read mux; the low bytes come from the hold taken at the high-byte read
   always_comb begin
      rbyte = 8'h00;
      if (aligned) begin
         unique case (idx)
            IDX_PORT_CONFIG: rbyte = {6'h00, state_ff.fmt};
            IDX_BC_SEL_LO:   rbyte = state_ff.bc_sel[7:0];
            IDX_BC_SEL_HI:   rbyte = state_ff.bc_sel[15:8];
            IDX_RAW_TEN_BIT_STREAM_ID:    rbyte = {state_ff.ids.ten_bit_virtual_channel,
                                      state_ff.ids.ten_bit_data_type};
            IDX_RAW_TWELVE_BIT_STREAM_ID:    rbyte = {state_ff.ids.twelve_bit_virtual_channel,
                                      state_ff.ids.twelve_bit_data_type};
            IDX_RESERVED:    rbyte = state_ff.rsvd;
            IDX_LINES_HI:    rbyte = state_ff.lines_rep[15:8]; // R10
            IDX_LINES_LO:    rbyte = state_ff.lines_lo_hold; // R12
            IDX_LEN_HI:      rbyte = state_ff.len_rep[15:8]; // R13
            IDX_LEN_LO:      rbyte = state_ff.len_lo_hold; // R15
            IDX_FREQ_CTL:    rbyte = state_ff.fcfg;
            IDX_CLK_STATUS:  rbyte = meas_mhz;
            IDX_IRQ_STATUS:  rbyte = {4'h0, state_ff.irq_status};
            IDX_IRQ_MASK:    rbyte = {4'h0, state_ff.irq_mask};
            default:         rbyte = 8'h00;
         endcase
      end
   end

   // Video edge detection
   assign frame_end = state_ff.fv_d && !video.frame_valid;
   assign line_end  = state_ff.lv_d && !video.line_valid;
   // A line closing on the frame's last cycle still counts as the last line
   assign len_final = line_end ? state_ff.len_run : state_ff.len_last;

   // Next-state logic for the whole register bank
   always_comb begin
      nxt_state = state_ff;
      evt       = '0;

      // Strap caught once, on the first cycle after reset release
      if (state_ff.strap_pend) begin
         nxt_state.strap_pend = 1'b0;
         nxt_state.fmt        = rvc_fmt_e'(strap_link_format); // R1
      end

      // Line and line-length counters
      nxt_state.fv_d = video.frame_valid;
      nxt_state.lv_d = video.line_valid;
      if (video.line_valid && video.pixel_valid) begin
         nxt_state.len_run = state_ff.len_run + 16'h0001;
      end
      if (line_end) begin
         nxt_state.len_last = state_ff.len_run; // R13
         nxt_state.len_run  = 16'h0000;
         if (video.frame_valid || state_ff.fv_d) begin
            nxt_state.lines_run = state_ff.lines_run + 16'h0001;
         end
      end

      // Status captured once per frame unless held for software
      if (frame_end) begin
         nxt_state.lines_run = 16'h0000;
         if (!state_ff.lines_frz) begin
            nxt_state.lines_rep = state_ff.lines_run + 16'(line_end); // R19
            if (nxt_state.lines_rep != state_ff.lines_rep) begin
               evt[IRQ_LINES]      = 1'b1;
               nxt_state.lines_frz = state_ff.irq_mask[IRQ_LINES]; // R11
            end
         end
         if (!state_ff.len_frz) begin
            nxt_state.len_rep = len_final; // R19
            if (len_final != state_ff.len_rep) begin
               evt[IRQ_LEN]      = 1'b1;
               nxt_state.len_frz = state_ff.irq_mask[IRQ_LEN]; // R14
            end
         end
      end

      // Frequency detector rising events
      nxt_state.stable_d = fd_stable;
      nxt_state.slow_d   = fd_slow;
      evt[IRQ_STABLE]    = fd_stable && !state_ff.stable_d;
      evt[IRQ_SLOW]      = fd_slow && !state_ff.slow_d;

      // Bus handshake: accept, then one cycle with waitrequest low
      unique case (state_ff.bus)
         BUS_IDLE: begin
            if (accept) begin
               nxt_state.bus   = BUS_ACK;
               nxt_state.rdata = {24'h00_0000, rbyte};
               if (avs_req.read && aligned && idx == IDX_LINES_HI) begin
                  nxt_state.lines_lo_hold = state_ff.lines_rep[7:0]; // R12
                  nxt_state.lines_frz     = 1'b0; // R11
               end
               if (avs_req.read && aligned && idx == IDX_LEN_HI) begin
                  nxt_state.len_lo_hold = state_ff.len_rep[7:0]; // R15
                  nxt_state.len_frz     = 1'b0; // R14
               end
            end
         end
         BUS_ACK: begin
            nxt_state.bus = BUS_IDLE;
         end
      endcase

      // Writes land on the edge where waitrequest is seen low
      if (wr_ack) begin
         unique case (idx)
            IDX_PORT_CONFIG: nxt_state.fmt = rvc_fmt_e'(wbyte[1:0]); // R1
            IDX_BC_SEL_LO:   nxt_state.bc_sel[7:0] = wbyte; // R2
            IDX_BC_SEL_HI:   nxt_state.bc_sel[15:8] = wbyte; // R2
            IDX_RAW_TEN_BIT_STREAM_ID:    begin
               nxt_state.ids.ten_bit_virtual_channel = wbyte[7:6]; // R6
               nxt_state.ids.ten_bit_data_type       = wbyte[5:0]; // R7
            end
            IDX_RAW_TWELVE_BIT_STREAM_ID:    begin
               nxt_state.ids.twelve_bit_virtual_channel = wbyte[7:6]; // R8
               nxt_state.ids.twelve_bit_data_type       = wbyte[5:0]; // R9
            end
            IDX_RESERVED:    nxt_state.rsvd = wbyte;
            IDX_FREQ_CTL:    nxt_state.fcfg = wbyte; // R16
            IDX_IRQ_MASK:    nxt_state.irq_mask = wbyte[IRQ_W-1:0];
            default:         ;
         endcase
      end

      // Sticky status, write one to clear, a new event wins over the clear
      if (wr_ack && idx == IDX_IRQ_STATUS) begin
         nxt_state.irq_status = state_ff.irq_status & ~wbyte[IRQ_W-1:0];
      end
      nxt_state.irq_status = nxt_state.irq_status | evt;
      nxt_state.irq        = |(nxt_state.irq_status & nxt_state.irq_mask);

      // Back-channel bits registered so outputs come from flops
      nxt_state.bc_out = bc_bit;
   end

   // State register; reset gives selectors 0x8 and virtual channels from the port number
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_ff <= RST_STATE; // R5
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs straight from flops
   assign avs_rsp.readdata    = state_ff.rdata;
   assign avs_rsp.waitrequest = (state_ff.bus != BUS_ACK);
   assign backchannel_bits    = state_ff.bc_out;
   assign link_input_format   = state_ff.fmt;
   assign stream_ids          = state_ff.ids;
   assign clock_stable        = fd_stable;
   assign clock_too_slow      = fd_slow;
   assign irq                 = state_ff.irq;

endmodule

// file: tb/rvc_serializer_model.sv
// Remote serializer: link ticks, back-channel capture
`timescale 1ns/1ns
module rvc_serializer_model (
   // Clock
   input  wire logic       clock,
   // Link period in cycles, zero stops it
   input  wire logic [7:0] tick_gap,
   // Link side
   output logic            link_clk_tick,
   input  wire logic [3:0] backchannel_bits,
   output logic [3:0]      rx_bits
);
   logic [7:0] cnt_ff = 8'h00;
   // One tick per period; capture adds a link delay
   always_ff @(posedge clock) begin
      cnt_ff <= (cnt_ff + 8'h01 >= tick_gap) ? 8'h00 : cnt_ff + 8'h01;
      link_clk_tick <= (tick_gap != 8'h00) && (cnt_ff == 8'h00);
      rx_bits <= backchannel_bits;
   end
endmodule

// file: tb/rvc_port_regs_assertions.sv
// Port register checker
`timescale 1ns/1ns
module rvc_port_regs_assertions
   import rvc_pkg::*;
#(
   parameter logic [1:0] PORT_NUM = 2'h0
)(
   // Clock and reset
   input wire logic            clock,
   input wire logic            sys_rst,
   // Bus
   input wire rvc_avs_req_s    avs_req,
   input wire rvc_avs_rsp_s    avs_rsp,
   // Pins and outputs
   input wire logic [1:0]      strap_link_format,
   input wire logic [7:0]      local_pins,
   input wire logic            camera_sync_pulse,
   input wire logic [3:0]      backchannel_bits,
   input wire rvc_fmt_e        link_input_format,
   input wire rvc_stream_ids_s stream_ids
);
   logic [15:0] sel_ff;
   logic [15:0] nxt_sel;
   logic [3:0]  exp_bc;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Mirror selectors from acked writes
   always_comb begin
      nxt_sel = sel_ff;
      if (avs_req.write && !avs_rsp.waitrequest && avs_req.byteenable[0]) begin
         if (avs_req.address == {IDX_BC_SEL_LO, WORD_OFS}) nxt_sel[7:0] = avs_req.writedata[7:0];
         if (avs_req.address == {IDX_BC_SEL_HI, WORD_OFS}) nxt_sel[15:8] = avs_req.writedata[7:0];
      end
      for (int i = 0; i < 4; i++) begin
         exp_bc[i] = sel_ff[4*i+3] ? (sel_ff[4*i+:4] == BC_CONST1) ||
            (sel_ff[4*i+:4] == BC_SYNC && camera_sync_pulse) : local_pins[sel_ff[4*i+:3]];
      end
   end
   always_ff @(posedge clock) begin
      sel_ff <= sys_rst ? {4{BC_SEL_RST}} : nxt_sel;
   end
   a_ack_one_cycle: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
      else $error("ack too long");
   a_ack_has_req: assert property ($fell(avs_rsp.waitrequest) |-> $past(avs_req.read || avs_req.write))
      else $error("ack without request");
   a_req_answered: assert property ((avs_req.read || avs_req.write) |-> ##[0:2] !avs_rsp.waitrequest)
      else $error("request unanswered");
   a_rdata_byte_wide: assert property (!avs_rsp.waitrequest |-> avs_rsp.readdata[31:8] == 24'h0)
      else $error("read data upper bits");
   a_bc_select: assert property (backchannel_bits == $past(exp_bc))
      else $error("back-channel source");
   a_bc_reset_zero: assert property ($fell(sys_rst) |-> backchannel_bits == 4'h0 ##1 backchannel_bits == 4'h0)
      else $error("back-channel reset");
   a_ids_reset: assert property ($fell(sys_rst) |-> stream_ids == {PORT_NUM, DT_RAW10_RST, PORT_NUM, DT_RAW12_RST})
      else $error("stream id reset");
   a_fmt_strap: assert property ($fell(sys_rst) |=> link_input_format == $past(strap_link_format))
      else $error("format strap");
   c_write: cover property (avs_req.write && !avs_rsp.waitrequest);
   c_read: cover property (avs_req.read && !avs_rsp.waitrequest);
   c_bc_mixed: cover property (backchannel_bits == 4'hB);
endmodule
bind rvc_port_regs rvc_port_regs_assertions #(.PORT_NUM(PORT_NUM)) u_assert (
   .clock(clock), .sys_rst(sys_rst), .avs_req(avs_req), .avs_rsp(avs_rsp),
   .strap_link_format(strap_link_format), .local_pins(local_pins),
   .camera_sync_pulse(camera_sync_pulse), .backchannel_bits(backchannel_bits),
   .link_input_format(link_input_format), .stream_ids(stream_ids));

// file: tb/test_rvc_port_regs.sv
// Bench for the port register block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module test_rvc_port_regs
   import rvc_pkg::*;
;
   logic            clock = 1'b0;
   logic            sys_rst = 1'b1;
   rvc_avs_req_s    req = '0;
   rvc_avs_rsp_s    rsp;
   rvc_video_s      vid = '0;
   logic [7:0]      pins = 8'h00;
   logic            sync = 1'b0;
   logic [7:0]      gap = 8'h0A;
   logic            tick, stable, slow, irq;
   logic [3:0]      bc, rx;
   rvc_fmt_e        fmt;
   rvc_stream_ids_s ids;
   int              n_mismatch = 0;
   int              checks_done = 0;
   int              cyc = 0;
   rvc_port_regs #(.PORT_NUM(2'h2)) rvc_port_regs_inst (.clock(clock), .sys_rst(sys_rst),
      .avs_req(req), .avs_rsp(rsp), .video(vid), .link_clk_tick(tick),
      .strap_link_format(2'h3), .local_pins(pins), .camera_sync_pulse(sync),
      .backchannel_bits(bc), .link_input_format(fmt), .stream_ids(ids),
      .clock_stable(stable), .clock_too_slow(slow), .irq(irq));
   rvc_serializer_model rvc_serializer_model_inst (.clock(clock), .tick_gap(gap),
      .link_clk_tick(tick), .backchannel_bits(bc), .rx_bits(rx));
   // Clock and hang guard
   initial forever #5 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         test_done;
      end
   end
   task test_done;
      if (n_mismatch == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task wt(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // One transfer, held until waitrequest low
   task bus(logic wr, logic [9:0] a, logic [7:0] d, output logic [7:0] q);
      @(posedge clock);
      req <= '{address: a, read: !wr, write: wr, writedata: {24'h0, d}, byteenable: 4'hF};
      do @(posedge clock); while (rsp.waitrequest !== 1'b0);
      q = rsp.readdata[7:0];
      {req.read, req.write} <= 2'b00;
   endtask
   task wr(logic [7:0] idx, d);
      logic [7:0] q;
      bus(1'b1, {idx, 2'b00}, d, q);
   endtask
   task chk(logic [7:0] idx, e);
      logic [7:0] q;
      bus(1'b0, {idx, 2'b00}, 8'h00, q);
      `CHK("register", e, q)
   endtask
   // High byte, then low byte
   task rd16(logic [7:0] idx, logic [15:0] e);
      chk(idx, e[15:8]);
      chk(idx + 8'h01, e[7:0]);
   endtask
   task wait_lvl(logic v, int lim, output int n);
      n = 0;
      while (stable !== v && n < lim) begin
         wt(1);
         n++;
      end
   endtask
   task vframe(int n, last);
      @(posedge clock);
      vid.frame_valid <= 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         {vid.line_valid, vid.pixel_valid} <= 2'b11;
         repeat ((i == n - 1) ? last : 5) @(posedge clock);
         {vid.line_valid, vid.pixel_valid} <= 2'b00;
      end
      @(posedge clock);
      vid.frame_valid <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   task t_reset;
      logic [15:0] tbl [10] = '{16'h6E88, 16'h6F88, 16'h70AB, 16'h71AC, 16'h7200,
                                16'h7300, 16'h7400, 16'h7500, 16'h7600, 16'h77C5};
      for (int i = 0; i < 10; i++) chk(tbl[i][15:8], tbl[i][7:0]);
      `CHK("format", FMT_RAW10, fmt)
      `CHK("bc reset", 4'h0, rx)
   endtask
   task t_freq;
      int n;
      wt(3300);
      `CHK("stable early", 1'b0, stable)
      wait_lvl(1'b1, 2000, n);
      `CHK("stable 40us", 1'b1, n inside {[300:1300]})
      `CHK("slow", 1'b0, slow)
      chk(IDX_CLK_STATUS, 8'h0A);
      wr(IDX_IRQ_MASK, 8'h04);
      wt(2);
      `CHK("irq set", 1'b1, irq)
      wr(IDX_IRQ_STATUS, 8'h04);
      wt(2);
      `CHK("irq clear", 1'b0, irq)
      wr(IDX_IRQ_MASK, 8'h00);
      @(posedge clock);
      gap <= 8'h0B;
      wt(500);
      chk(IDX_CLK_STATUS, 8'h0A);
      `CHK("stable kept", 1'b1, stable)
      @(posedge clock);
      gap <= 8'h19;
      wr(IDX_FREQ_CTL, 8'h1C); // No hysteresis, 80 us, threshold 12
      wait_lvl(1'b0, 400, n);
      `CHK("unstable", 1'b1, n < 400)
      wt(300);
      chk(IDX_CLK_STATUS, 8'h04);
      `CHK("slow thr", 1'b1, slow)
      wt(6000);
      `CHK("early 80us", 1'b0, stable)
      wait_lvl(1'b1, 3000, n);
      `CHK("stable 80us", 1'b1, n inside {[800:2900]})
   endtask
   task t_format;
      for (int c = 0; c < 4; c++) begin
         wr(IDX_PORT_CONFIG, 8'(c));
         wt(2);
         `CHK("format", rvc_fmt_e'(c), fmt)
      end
   endtask
   task t_backchannel;
      wr(IDX_BC_SEL_LO, 8'h93); // Const one, pin 3
      wr(IDX_BC_SEL_HI, 8'hAB); // Sync, reserved
      chk(IDX_BC_SEL_LO, 8'h93);
      @(posedge clock);
      pins <= 8'h08;
      sync <= 1'b1;
      wt(3);
      `CHK("bc on", 4'hB, rx)
      @(posedge clock);
      pins <= 8'hF7;
      sync <= 1'b0;
      wt(3);
      `CHK("bc off", 4'h2, rx)
   endtask
   task t_regs;
      logic [7:0] q;
      wr(IDX_RAW_TEN_BIT_STREAM_ID, 8'h5A);
      wr(IDX_RAW_TWELVE_BIT_STREAM_ID, 8'hC3);
      wt(2);
      `CHK("ids", 16'h5AC3, ids)
      wr(IDX_RESERVED, 8'h5A);
      chk(IDX_RESERVED, 8'h5A);
      wr(IDX_LINES_HI, 8'hFF);
      chk(IDX_LINES_HI, 8'h00);
      chk(8'hFF, 8'h00);
      bus(1'b0, 10'h1B9, 8'h00, q);
      `CHK("unaligned", 8'h00, q)
   endtask
   task t_video;
      vframe(3, 300);
      rd16(IDX_LINES_HI, 16'h0003);
      rd16(IDX_LEN_HI, 16'h012C);
      wr(IDX_IRQ_STATUS, 8'h03);
      wr(IDX_IRQ_MASK, 8'h03);
      vframe(2, 4);
      wt(2);
      `CHK("irq frame", 1'b1, irq)
      vframe(1, 6);
      rd16(IDX_LINES_HI, 16'h0002);
      rd16(IDX_LEN_HI, 16'h0004);
      vframe(1, 6);
      rd16(IDX_LINES_HI, 16'h0001);
      rd16(IDX_LEN_HI, 16'h0006);
      wr(IDX_IRQ_MASK, 8'h00);
      wt(2);
      `CHK("irq masked", 1'b0, irq)
   endtask
   initial begin
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset;
      t_freq;
      t_format;
      t_backchannel;
      t_regs;
      t_video;
      test_done;
   end
endmodule
